// [shared/ipd_defines.vh]
// Constants for the indexed postbyte decoder
`ifndef IPD_DEFINES_VH
`define IPD_DEFINES_VH
`define IPD_PAGE2_PREFIX     8'h18
`define IPD_BASE_X           2'h0
`define IPD_BASE_Y           2'h1
`define IPD_BASE_SP          2'h2
`define IPD_BASE_PC          2'h3
`define IPD_ACC_A            2'h0
`define IPD_ACC_B            2'h1
`define IPD_ACC_D            2'h2
`define IPD_ACC_DIND         2'h3
`define IPD_PB_CONST5_BIT    5
`define IPD_PB_LONG_TOP      3'h7
`define IPD_PB_RR_HI         7
`define IPD_PB_RR_LO         6
`define IPD_PB_LRR_HI        4
`define IPD_PB_LRR_LO        3
`define IPD_PB_KIND_BIT      2
`define IPD_PB_Z_BIT         1
`define IPD_PB_S_BIT         0
`define IPD_PB_P_BIT         4
`define IPD_PB_N4_SIGN       3
// Offset kinds reported to the address datapath
`define IPD_KIND_CONST5      3'h0
`define IPD_KIND_CONST9      3'h1
`define IPD_KIND_CONST16     3'h2
`define IPD_KIND_IND16       3'h3
`define IPD_KIND_AUTO        3'h4
`define IPD_KIND_ACC         3'h5
`define IPD_KIND_DIND        3'h6
`define IPD_KIND_ILLEGAL     3'h7
// Opcode classes from the classifier
`define IPD_CLS_NONE         2'h0
`define IPD_CLS_INDEXED      2'h1
`define IPD_CLS_POSTBYTE     2'h2
`define IPD_CLS_EXT          2'h3
`endif

// [verilog/ipd_opclass_rom.v]
// Registered opcode class lookup for both opcode pages
`include "ipd_defines.vh"
module ipd_opclass_rom (
    input  wire       core_clk_in,     // Core clock
    input  wire       reset_in,        // Async reset, active high
    input  wire       clk_en_in,       // Clock enable
    input  wire       page2_in,        // Second page select
    input  wire [7:0] opcode_in,       // Opcode byte
    output reg  [1:0] class_out,       // Registered opcode class
    output reg  [1:0] ext_count_out    // Registered extension byte count
);
    reg [1:0] cls_d;
    reg [1:0] cnt_d;
    // Class decode: indexed columns, postbyte and extended forms
    always @* begin
        cls_d = `IPD_CLS_NONE;
        cnt_d = 2'h0;
        if (opcode_in[7:4] == 4'hA || opcode_in[7:4] == 4'hE ||
            (!page2_in && opcode_in[7:4] == 4'h6)) begin
            cls_d = `IPD_CLS_INDEXED;
        end else if (!page2_in && (opcode_in == 8'hB7 || opcode_in == 8'h04)) begin
            cls_d = `IPD_CLS_POSTBYTE;
            cnt_d = (opcode_in == 8'h04) ? 2'h1 : 2'h0;
        end else if (opcode_in[7:4] == 4'hB || opcode_in[7:4] == 4'hF) begin
            cls_d = `IPD_CLS_EXT;
            cnt_d = 2'h2;
        end else if (opcode_in[7:4] == 4'h9 || opcode_in[7:4] == 4'hD ||
                     opcode_in[7:4] == 4'h8 || opcode_in[7:4] == 4'hC) begin
            cls_d = `IPD_CLS_EXT;
            cnt_d = 2'h1;
        end
    end
    // Output register
    always @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            class_out     <= `IPD_CLS_NONE;
            ext_count_out <= 2'h0;
        end else if (clk_en_in) begin
            class_out     <= cls_d;
            ext_count_out <= cnt_d;
        end
    end
endmodule

// [verilog/ipd_decoder.v]
// Indexed postbyte decoder with effective address and auto-modify
`include "ipd_defines.vh"
module ipd_decoder (
    input  wire        core_clk_in,         // Core clock, 50 MHz
    input  wire        reset_in,            // Async reset, active high
    input  wire        clk_en_in,           // Clock enable, freezes all state
    input  wire        byte_valid_in,       // Instruction byte presented
    input  wire [7:0]  byte_in,             // Instruction stream byte
    input  wire [15:0] reg_x_in,            // Index register X
    input  wire [15:0] reg_y_in,            // Index register Y
    input  wire [15:0] reg_sp_in,           // Stack pointer
    input  wire [15:0] reg_pc_in,           // Program counter
    input  wire [7:0]  acc_a_in,            // Accumulator A
    input  wire [7:0]  acc_b_in,            // Accumulator B
    output reg         byte_ready_out,      // Decoder can take a byte
    output reg         done_out,            // Decode complete pulse
    output reg         page2_out,           // Opcode from second page
    output reg  [7:0]  opcode_out,          // Decoded opcode
    output reg  [1:0]  opclass_out,         // Opcode class
    output reg  [7:0]  indexed_postbyte_out,// Captured postbyte
    output reg  [15:0] ext_field_out,       // Assembled extension field
    output reg  [2:0]  offset_kind_out,     // Offset kind
    output reg  [1:0]  base_register_select_out, // Base register
    output reg  [15:0] eff_addr_out,        // Effective address
    output reg         indirect_out,        // Fetch pointer at eff_addr
    output reg         wb_en_out,           // Write back base register
    output reg  [15:0] wb_value_out,        // Adjusted base value
    output reg         illegal_out          // Invalid postbyte form
);
    localparam [4:0] ST_OPCODE = 5'h01;
    localparam [4:0] ST_CLASS  = 5'h02;
    localparam [4:0] ST_POST   = 5'h04;
    localparam [4:0] ST_EXT    = 5'h08;
    localparam [4:0] ST_DONE   = 5'h10;

    reg  [4:0]  state_q;
    reg  [4:0]  state_d;
    reg         page2_q;
    reg  [7:0]  opcode_q;
    reg  [7:0]  post_q;
    reg  [15:0] ext_q;
    reg  [1:0]  need_q;
    reg         has_post_q;
    wire [1:0]  rom_class;
    wire [1:0]  rom_count;
    wire        take_c;

    // A byte counts only when offered and accepted
    assign take_c = byte_valid_in && byte_ready_out;

    // Opcode class lookup, page aware
    ipd_opclass_rom u_rom (
        .core_clk_in   (core_clk_in),
        .reset_in      (reset_in),
        .clk_en_in     (clk_en_in),
        .page2_in      (page2_q),
        .opcode_in     (byte_in),
        .class_out     (rom_class),
        .ext_count_out (rom_count)
    );

    // Extension bytes implied by an indexed postbyte
    function [1:0] ipd_post_ext;
        input [7:0] pb;
        begin
            if (pb[7:5] == `IPD_PB_LONG_TOP && !pb[`IPD_PB_KIND_BIT]) begin
                ipd_post_ext = pb[`IPD_PB_Z_BIT] ? 2'h2 : 2'h1;
            end else begin
                ipd_post_ext = 2'h0;
            end
        end
    endfunction

    // Base register value from the two-bit field
    function [15:0] ipd_base;
        input [1:0]  sel;
        input [15:0] x;
        input [15:0] y;
        input [15:0] sp;
        input [15:0] pc;
        begin
            case (sel)
                `IPD_BASE_X:  ipd_base = x;
                `IPD_BASE_Y:  ipd_base = y;
                `IPD_BASE_SP: ipd_base = sp;
                default:      ipd_base = pc;
            endcase
        end
    endfunction

    // Next state of the byte sequencer
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OPCODE: if (take_c && (byte_in != `IPD_PAGE2_PREFIX || page2_q)) begin
                state_d = ST_CLASS;
            end
            ST_CLASS: begin
                if (rom_class == `IPD_CLS_INDEXED || rom_class == `IPD_CLS_POSTBYTE) begin
                    state_d = ST_POST;
                end else if (rom_count != 2'h0) begin
                    state_d = ST_EXT;
                end else begin
                    state_d = ST_DONE;
                end
            end
            ST_POST: if (take_c) begin
                if (opclass_out == `IPD_CLS_INDEXED && ipd_post_ext(byte_in) != 2'h0) begin
                    state_d = ST_EXT;
                end else if (opclass_out == `IPD_CLS_POSTBYTE && need_q != 2'h0) begin
                    state_d = ST_EXT;
                end else begin
                    state_d = ST_DONE;
                end
            end
            ST_EXT: if (take_c && need_q == 2'h1) begin
                state_d = ST_DONE;
            end
            ST_DONE: state_d = ST_OPCODE;
            default: state_d = ST_OPCODE;
        endcase
    end

    // Byte capture and sequencing
    always @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q     <= ST_OPCODE;
            page2_q     <= 1'b0;
            opcode_q    <= 8'h00;
            post_q      <= 8'h00;
            ext_q       <= 16'h0000;
            need_q      <= 2'h0;
            has_post_q  <= 1'b0;
            opclass_out <= `IPD_CLS_NONE;
        end else if (clk_en_in) begin
            state_q <= state_d;
            case (state_q)
                ST_OPCODE: if (take_c) begin
                    if (byte_in == `IPD_PAGE2_PREFIX && !page2_q) begin
                        page2_q <= 1'b1;
                    end else begin
                        opcode_q   <= byte_in;
                        ext_q      <= 16'h0000;
                        has_post_q <= 1'b0;
                    end
                end
                ST_CLASS: begin
                    opclass_out <= rom_class;
                    need_q      <= rom_count;
                end
                ST_POST: if (take_c) begin
                    post_q     <= byte_in;
                    has_post_q <= 1'b1;
                    if (opclass_out == `IPD_CLS_INDEXED) begin
                        need_q <= ipd_post_ext(byte_in);
                    end
                end
                ST_EXT: if (take_c) begin
                    ext_q  <= {ext_q[7:0], byte_in};
                    need_q <= need_q - 2'h1;
                end
                ST_DONE: page2_q <= 1'b0;
                default: page2_q <= 1'b0;
            endcase
        end
    end

    // Postbyte fields and effective address formation
    reg  [2:0]  kind_c;
    reg  [1:0]  base_c;
    reg  [15:0] off_c;
    reg  [15:0] base_v;
    reg  [15:0] adj_v;
    reg         ind_c;
    reg         wb_c;
    reg         ill_c;
    always @* begin
        kind_c = `IPD_KIND_CONST5;
        base_c = post_q[`IPD_PB_RR_HI:`IPD_PB_RR_LO];
        off_c  = 16'h0000;
        ind_c  = 1'b0;
        wb_c   = 1'b0;
        ill_c  = 1'b0;
        if (post_q[7:5] == `IPD_PB_LONG_TOP) begin
            base_c = post_q[`IPD_PB_LRR_HI:`IPD_PB_LRR_LO];
        end
        base_v = ipd_base(base_c, reg_x_in, reg_y_in, reg_sp_in, reg_pc_in);
        if (!post_q[`IPD_PB_CONST5_BIT]) begin
            kind_c = `IPD_KIND_CONST5;
            off_c  = {{11{post_q[4]}}, post_q[4:0]};
        end else if (post_q[7:5] != `IPD_PB_LONG_TOP) begin
            kind_c = `IPD_KIND_AUTO;
            off_c  = post_q[`IPD_PB_N4_SIGN] ? {{12{1'b1}}, post_q[3:0]}
                                             : {12'h000, post_q[3:0]} + 16'h0001;
            wb_c   = (base_c != `IPD_BASE_PC);
            ill_c  = (base_c == `IPD_BASE_PC);
        end else if (!post_q[`IPD_PB_KIND_BIT]) begin
            if (!post_q[`IPD_PB_Z_BIT]) begin
                kind_c = `IPD_KIND_CONST9;
                off_c  = {{8{post_q[`IPD_PB_S_BIT]}}, ext_q[7:0]};
            end else begin
                kind_c = post_q[`IPD_PB_S_BIT] ? `IPD_KIND_IND16 : `IPD_KIND_CONST16;
                off_c  = ext_q;
                ind_c  = post_q[`IPD_PB_S_BIT];
            end
        end else begin
            case (post_q[1:0])
                `IPD_ACC_A: off_c = {8'h00, acc_a_in};
                `IPD_ACC_B: off_c = {8'h00, acc_b_in};
                default:    off_c = {acc_a_in, acc_b_in};
            endcase
            kind_c = (post_q[1:0] == `IPD_ACC_DIND) ? `IPD_KIND_DIND : `IPD_KIND_ACC;
            ind_c  = (post_q[1:0] == `IPD_ACC_DIND);
        end
        adj_v = base_v + off_c;
    end

    // Registered outputs
    always @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            byte_ready_out           <= 1'b0;
            done_out                 <= 1'b0;
            page2_out                <= 1'b0;
            opcode_out               <= 8'h00;
            indexed_postbyte_out     <= 8'h00;
            ext_field_out            <= 16'h0000;
            offset_kind_out          <= `IPD_KIND_CONST5;
            base_register_select_out <= `IPD_BASE_X;
            eff_addr_out             <= 16'h0000;
            indirect_out             <= 1'b0;
            wb_en_out                <= 1'b0;
            wb_value_out             <= 16'h0000;
            illegal_out              <= 1'b0;
        end else if (clk_en_in) begin
            byte_ready_out <= (state_d == ST_OPCODE) || (state_d == ST_POST) ||
                              (state_d == ST_EXT);
            done_out       <= (state_q == ST_DONE);
            if (state_q == ST_DONE) begin
                page2_out            <= page2_q;
                opcode_out           <= opcode_q;
                indexed_postbyte_out <= post_q;
                ext_field_out        <= ext_q;
                if (opclass_out == `IPD_CLS_INDEXED && has_post_q) begin
                    offset_kind_out          <= ill_c ? `IPD_KIND_ILLEGAL : kind_c;
                    base_register_select_out <= base_c;
                    indirect_out             <= ind_c;
                    wb_en_out                <= wb_c;
                    wb_value_out             <= adj_v;
                    illegal_out              <= ill_c;
                    // Post-modify addresses with the original base
                    if (kind_c == `IPD_KIND_AUTO && post_q[`IPD_PB_P_BIT]) begin
                        eff_addr_out <= base_v;
                    end else begin
                        eff_addr_out <= adj_v;
                    end
                end else begin
                    offset_kind_out <= `IPD_KIND_CONST5;
                    indirect_out    <= 1'b0;
                    wb_en_out       <= 1'b0;
                    illegal_out     <= 1'b0;
                    eff_addr_out    <= ext_q;
                end
            end
        end
    end
endmodule

// [verification/ipd_decoder_assertions.sv]
// Concurrent checks on the indexed postbyte decoder results
`include "ipd_defines.vh"
module ipd_checker (
    input wire        core_clk_in,              // Clock
    input wire        reset_in,                 // Reset
    input wire        clk_en_in,                // Enable
    input wire [15:0] reg_x_in,                 // X
    input wire [15:0] reg_y_in,                 // Y
    input wire [15:0] reg_sp_in,                // SP
    input wire [15:0] reg_pc_in,                // PC
    input wire [7:0]  acc_a_in,                 // A
    input wire [7:0]  acc_b_in,                 // B
    input wire        done_out,                 // Done pulse
    input wire [1:0]  opclass_out,              // Class
    input wire [7:0]  indexed_postbyte_out,     // Postbyte
    input wire [15:0] ext_field_out,            // Extension
    input wire [2:0]  offset_kind_out,          // Kind
    input wire [1:0]  base_register_select_out, // Base
    input wire [15:0] eff_addr_out,             // Address
    input wire        indirect_out,             // Indirect
    input wire        wb_en_out,                // Writeback
    input wire [15:0] wb_value_out              // Writeback value
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [15:0] x_q, y_q, sp_q, pc_q;
    reg  [7:0]  a_q, b_q;
    // Expected fields worked out from the captured postbyte
    wire [7:0]  pb = indexed_postbyte_out;
    wire [1:0]  rr = (pb[7:5] == 3'h7) ? pb[4:3] : pb[7:6];
    wire [15:0] base = rr[1] ? (rr[0] ? pc_q : sp_q) : (rr[0] ? y_q : x_q);
    wire [15:0] acc = pb[1] ? {a_q, b_q} : {8'h00, pb[0] ? b_q : a_q};
    wire [15:0] adj = pb[3] ? {12'hFFF, pb[3:0]} : {12'h000, pb[3:0]} + 16'h0001;
    wire [2:0]  kind = !pb[5] ? `IPD_KIND_CONST5 : (pb[7:5] != 3'h7) ? `IPD_KIND_AUTO :
        !pb[2] ? (pb[1] ? (pb[0] ? `IPD_KIND_IND16 : `IPD_KIND_CONST16) : `IPD_KIND_CONST9) :
        (pb[1:0] == 2'h3 ? `IPD_KIND_DIND : `IPD_KIND_ACC);
    wire        idx = done_out && opclass_out == `IPD_CLS_INDEXED;
    // Registers as the decoder saw them in its last cycle
    always @(posedge core_clk_in) begin
        {x_q, y_q, sp_q, pc_q} <= {reg_x_in, reg_y_in, reg_sp_in, reg_pc_in};
        {a_q, b_q} <= {acc_a_in, acc_b_in};
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    chk_kind_decode: assert property (idx |-> offset_kind_out == kind)
        else $error("offset kind wrong");
    chk_base_field: assert property (idx |-> base_register_select_out == rr)
        else $error("base select wrong");
    chk_const5_addr: assert property (idx && kind == `IPD_KIND_CONST5 |->
        eff_addr_out == base + {{11{pb[4]}}, pb[4:0]}) else $error("5-bit address wrong");
    chk_const9_addr: assert property (idx && kind == `IPD_KIND_CONST9 |->
        eff_addr_out == base + {{8{pb[0]}}, ext_field_out[7:0]}) else $error("9-bit address wrong");
    chk_const16_addr: assert property (idx && pb[7:5] == 3'h7 && pb[2:1] == 2'h1 |->
        eff_addr_out == base + ext_field_out) else $error("16-bit address wrong");
    chk_indirect_flag: assert property (idx |-> indirect_out ==
        (kind == `IPD_KIND_IND16 || kind == `IPD_KIND_DIND)) else $error("indirect flag wrong");
    chk_acc_addr: assert property (idx && pb[7:5] == 3'h7 && pb[2] |->
        eff_addr_out == base + acc) else $error("accumulator address wrong");
    chk_auto_modify: assert property (idx && kind == `IPD_KIND_AUTO |-> wb_en_out &&
        rr != `IPD_BASE_PC && wb_value_out == base + adj &&
        eff_addr_out == (pb[4] ? base : base + adj)) else $error("auto modify wrong");
    chk_no_writeback: assert property (idx && kind != `IPD_KIND_AUTO |-> !wb_en_out)
        else $error("unexpected writeback");
    chk_done_pulse: assert property (done_out && clk_en_in |=> !done_out)
        else $error("done longer than one cycle");
    chk_ext_addr: assert property (done_out && opclass_out == `IPD_CLS_EXT |->
        eff_addr_out == ext_field_out) else $error("extension address wrong");
endmodule
bind ipd_decoder ipd_checker u_chk (.core_clk_in, .reset_in, .clk_en_in, .reg_x_in, .reg_y_in,
    .reg_sp_in, .reg_pc_in, .acc_a_in, .acc_b_in, .done_out, .opclass_out, .indexed_postbyte_out,
    .ext_field_out, .offset_kind_out, .base_register_select_out, .eff_addr_out, .indirect_out,
    .wb_en_out, .wb_value_out);

// [verification/ipd_fetch_model.sv]
// Fetch queue model presenting instruction bytes to the decoder
module ipd_fetch_model (
    input  wire        core_clk_in,    // Core clock
    input  wire        reset_in,       // Async reset
    input  wire        clk_en_in,      // Decoder enable
    input  wire        stall_in,       // Slow answer
    input  wire        byte_ready_in,  // Decoder ready
    output logic       byte_valid_out, // Byte presented
    output logic [7:0] byte_out        // Stream byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q_mem [16];
    int         wr_ptr, rd_ptr, nxt;
    // Append one byte at the queue tail
    task automatic push(input logic [7:0] b);
        q_mem[wr_ptr % 16] = b;
        wr_ptr++;
    endtask
    // Hold each byte until taken; idle line toggles so stale data never matches
    always @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_ptr = 0;
            wr_ptr = 0;
            byte_valid_out <= 1'b0;
            byte_out <= 8'h00;
        end else begin
            nxt = rd_ptr + ((byte_valid_out && byte_ready_in && clk_en_in) ? 1 : 0);
            if (nxt != wr_ptr &&
                (!stall_in || (byte_valid_out && nxt == rd_ptr))) begin
                byte_valid_out <= 1'b1;
                byte_out <= q_mem[nxt % 16];
            end else begin
                byte_valid_out <= 1'b0;
                byte_out <= ~byte_out;
            end
            rd_ptr = nxt;
        end
    end
endmodule

// [verification/test_indexed_postbyte_decoder.sv]
// Self-checking bench for the indexed postbyte decoder
`include "ipd_defines.vh"
module test_indexed_postbyte_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_in, reset_in, clk_en_in, stall, valid, ready, done, pg2, ind, wben, ill;
    logic [7:0]  bval, opc, pbo;
    logic [1:0]  cls, bsel;
    logic [2:0]  kind;
    logic [15:0] eff, ext, wbv;
    logic [15:0] rx = 16'h1000, ry = 16'h2000, rsp = 16'h3000, rpc = 16'h4000;
    logic [7:0]  ra = 8'h81, rb = 8'h7F;
    logic [15:0] bases [4];
    int          mismatches, n_checks;

    ipd_decoder dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
        .byte_valid_in(valid), .byte_in(bval), .reg_x_in(rx), .reg_y_in(ry), .reg_sp_in(rsp),
        .reg_pc_in(rpc), .acc_a_in(ra), .acc_b_in(rb), .byte_ready_out(ready), .done_out(done),
        .page2_out(pg2), .opcode_out(opc), .opclass_out(cls), .indexed_postbyte_out(pbo),
        .ext_field_out(ext), .offset_kind_out(kind), .base_register_select_out(bsel),
        .eff_addr_out(eff), .indirect_out(ind), .wb_en_out(wben), .wb_value_out(wbv),
        .illegal_out(ill));
    ipd_fetch_model fm (.core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
        .stall_in(stall), .byte_ready_in(ready), .byte_valid_out(valid), .byte_out(bval));

    // Counted four-state comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Queue bytes, then wait a bounded time for the done pulse
    task automatic send(input logic [7:0] b0, b1, b2, b3, input int n);
        logic [7:0] bs [4];
        int k;
        bs = '{b0, b1, b2, b3};
        for (k = 0; k < n; k++)
            fm.push(bs[k]);
        k = 0;
        do begin
            @(posedge core_clk_in);
            #1;
            k++;
        end while (done !== 1'b1 && k < 60);
        if (done !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t no done", $time);
            print_verdict;
        end
    endtask
    // Kind, base and address of the last result
    task automatic chk_res(input logic [2:0] k, input logic [1:0] r, input logic [15:0] a);
        chk(16'(kind), 16'(k));
        chk(16'(bsel), 16'(r));
        chk(eff, a);
        chk(16'(ill), 16'h0000);
    endtask
    task automatic t_const5;
        int r;
        for (r = 0; r < 4; r++) begin
            send(8'hA6, {r[1:0], 6'h10}, 8'h00, 8'h00, 2);
            chk_res(`IPD_KIND_CONST5, r[1:0], bases[r] - 16'h0010);
            send(8'hA6, {r[1:0], 6'h0F}, 8'h00, 8'h00, 2);
            chk_res(`IPD_KIND_CONST5, r[1:0], bases[r] + 16'h000F);
        end
    endtask
    task automatic t_const;
        send(8'hA6, 8'hE1, 8'h10, 8'h00, 3);
        chk_res(`IPD_KIND_CONST9, 2'h0, rx + 16'hFF10);
        chk({8'h00, pbo}, 16'h00E1);
        chk(ext, 16'h0010);
        send(8'hA6, 8'hE8, 8'h7F, 8'h00, 3);
        chk_res(`IPD_KIND_CONST9, 2'h1, ry + 16'h007F);
        send(8'hA6, 8'hEA, 8'h12, 8'h34, 4);
        chk_res(`IPD_KIND_CONST16, 2'h1, ry + 16'h1234);
        chk(ext, 16'h1234);
        send(8'hA6, 8'hF3, 8'h80, 8'h01, 4);
        chk_res(`IPD_KIND_IND16, 2'h2, rsp + 16'h8001);
        chk(16'(ind), 16'h0001);
    endtask
    // Auto modify, with the enable dropped before the opcode byte is taken
    task automatic t_auto;
        fork
            begin
                @(posedge core_clk_in);
                clk_en_in <= 1'b0;
                repeat (3) @(posedge core_clk_in);
                clk_en_in <= 1'b1;
            end
        join_none
        send(8'hA6, 8'hA8, 8'h00, 8'h00, 2);
        chk_res(`IPD_KIND_AUTO, 2'h2, rsp - 16'h0008);
        chk(wbv, rsp - 16'h0008);
        send(8'hA6, 8'h37, 8'h00, 8'h00, 2);
        chk_res(`IPD_KIND_AUTO, 2'h0, rx);
        chk(wbv, rx + 16'h0008);
        chk(16'(wben), 16'h0001);
    endtask
    task automatic t_acc;
        logic [7:0]  pbs [4];
        logic [15:0] offs [4];
        logic [2:0]  kinds [4];
        int i;
        pbs = '{8'hE4, 8'hED, 8'hF6, 8'hFF};
        offs = '{16'h0081, 16'h007F, 16'h817F, 16'h817F};
        kinds = '{`IPD_KIND_ACC, `IPD_KIND_ACC, `IPD_KIND_ACC, `IPD_KIND_DIND};
        for (i = 0; i < 4; i++) begin
            send(8'hA6, pbs[i], 8'h00, 8'h00, 2);
            chk_res(kinds[i], i[1:0], bases[i] + offs[i]);
            chk(16'(ind), 16'(i == 3));
        end
    endtask
    // Second page prefix, then an extension-only opcode under a slow queue
    task automatic t_page;
        send(8'h18, 8'hA6, 8'h00, 8'h00, 3);
        chk(16'(pg2), 16'h0001);
        chk_res(`IPD_KIND_CONST5, 2'h0, rx);
        @(posedge core_clk_in);
        stall <= 1'b1;
        #1;
        fork
            begin
                repeat (4) @(posedge core_clk_in);
                stall <= 1'b0;
            end
        join_none
        send(8'hB6, 8'h12, 8'h34, 8'h00, 3);
        chk({7'h00, pg2, opc}, 16'h00B6);
        chk(16'(cls), 16'(`IPD_CLS_EXT));
        chk(eff, 16'h1234);
        send(8'h04, 8'h20, 8'h05, 8'h00, 3);
        chk({8'h00, pbo}, 16'h0020);
        chk(16'(cls), 16'(`IPD_CLS_POSTBYTE));
        chk(eff, 16'h0005);
        send(8'h18, 8'h18, 8'h00, 8'h00, 2);
        chk({7'h00, pg2, opc}, 16'h0118);
    endtask
    // Reset in mid-instruction clears results and decoding restarts
    task automatic t_reset;
        fm.push(8'hA6);
        fm.push(8'hEA);
        fm.push(8'h12);
        repeat (4) @(posedge core_clk_in);
        reset_in <= 1'b1;
        @(posedge core_clk_in);
        #1;
        chk(16'(done), 16'h0000);
        chk(16'(ready), 16'h0000);
        chk(eff, 16'h0000);
        @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        send(8'hA6, 8'h00, 8'h00, 8'h00, 2);
        chk_res(`IPD_KIND_CONST5, 2'h0, rx);
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    initial begin
        reset_in = 1'b1;
        clk_en_in = 1'b1;
        stall = 1'b0;
        bases = '{rx, ry, rsp, rpc};
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        t_const5;
        t_const;
        t_auto;
        t_acc;
        t_page;
        t_reset;
        print_verdict;
    end
endmodule
